// >>> rtl/posc_regs.vh
`ifndef POSC_REGS_VH
`define POSC_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define POSC_OFS_ACTION 8'h00
`define POSC_OFS_C3TIME 8'h04
`define POSC_OFS_PLLTMR 8'h08
`define POSC_OFS_SLPCMD 8'h0C
`define POSC_OFS_PINSEL 8'h10
`define POSC_OFS_STATUS 8'h14

// ----------------------------------------
// Reset values
// ----------------------------------------
`define POSC_RST_ACTION 16'h8000
`define POSC_RST_C3TIME 2'h0
`define POSC_RST_PLLTMR 8'h0F
`define POSC_RST_SLPTYP 3'h0
`define POSC_RST_PINSEL 4'h0

// ----------------------------------------
// Action control fields
// ----------------------------------------
`define POSC_ACT_EN 0
`define POSC_ACT_SPARE 1
`define POSC_ACT_CPUSTP 2
`define POSC_ACT_PCISTP 3
`define POSC_ACT_GFXSTP 4
`define POSC_ACT_DC_STOP_PIN_ENABLE 5
`define POSC_ACT_SLEEP 6
`define POSC_ACT_SUSPEND_PIN_ENABLE 8
`define POSC_ACT_MOUSE 14
`define POSC_ACT_TIMER 15
`define POSC_ACT_WMASK 16'hC17F

// ----------------------------------------
// Sleep command fields
// ----------------------------------------
`define POSC_SLEEP_TYPE_FIELD_LSB 10
`define POSC_SLP_EN 13
`define POSC_SLEEP_TYPE_FIELD_POS 3'h1

// ----------------------------------------
// Pin function select fields
// ----------------------------------------
`define POSC_SEL_SLEEP 0
`define POSC_SEL_DC_STOP_PIN_ENABLE 1
`define POSC_SEL_GFXSTP 2
`define POSC_SEL_CPUSTP 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define POSC_CLK_NS 20
`define POSC_C3_DLY0_NS 1000
`define POSC_C3_DLY1_NS 32000
`define POSC_C3_DLY2_NS 64000
`define POSC_C3_DLY3_NS 128000
`define POSC_PLL_UNIT_PS 61035000
`define POSC_C3_DLY0_CYC ((`POSC_C3_DLY0_NS + `POSC_CLK_NS - 1) / `POSC_CLK_NS)
`define POSC_C3_DLY1_CYC (`POSC_C3_DLY1_NS / `POSC_CLK_NS)
`define POSC_C3_DLY2_CYC (`POSC_C3_DLY2_NS / `POSC_CLK_NS)
`define POSC_C3_DLY3_CYC (`POSC_C3_DLY3_NS / `POSC_CLK_NS)
`define POSC_PLL_UNIT_CYC (`POSC_PLL_UNIT_PS / (`POSC_CLK_NS * 1000))

`endif

// >>> rtl/posc_timer.v
`timescale 1ns/1ps
module posc_timer #(
    parameter W = 16
) (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // Control
    input wire start_i,
    input wire [W-1:0] load_i,
    // Status
    output wire busy_o,
    output reg done_o
);

reg [W-1:0] cnt_reg;

assign busy_o = (cnt_reg != {W{1'b0}});

always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        cnt_reg <= {W{1'b0}};
        done_o <= 1'b0;
    end else begin
        done_o <= 1'b0;
        if (start_i) begin
            cnt_reg <= load_i;
        end else if (busy_o) begin
            cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
            if (cnt_reg == {{(W-1){1'b0}}, 1'b1}) begin
                done_o <= 1'b1;
            end
        end
    end
end

endmodule // posc_timer

// >>> rtl/posc_top.v
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "posc_regs.vh"
module posc_top #(
    parameter C3_DLY3_CYC = `POSC_C3_DLY3_CYC,
    parameter PLL_UNIT_CYC = `POSC_PLL_UNIT_CYC,
    parameter TW = 20
) (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // Wake and link pins
    input wire wake_i,
    input wire link_halt_n_i,
    input wire c3_graphics_stop_i,
    // Interrupt sources and gated outputs
    input wire timer_irq_i,
    input wire mouse_irq_pin_i,
    input wire mouse_irq_serial_i,
    output reg timer_irq_o,
    output reg mouse_irq_o,
    // Power control pins
    output reg stop_grant_request_n_o,
    output reg suspend_n_o,
    output reg processor_sleep_n_o,
    output reg dc_stop_out_n_o,
    output reg graphics_stop_out_n_o,
    output reg pci_clock_halt_n_o,
    output reg processor_clock_halt_n_o
);

// ----------------------------------------
// States
// ----------------------------------------
localparam ST_IDLE = 4'b0001;
localparam ST_SUSPEND_PIN_ENABLE = 4'b0010;
localparam ST_REL1 = 4'b0100;
localparam ST_REL2 = 4'b1000;

reg [15:0] action_reg;
reg [1:0] c3_exit_timing_reg;
reg [7:0] pll_recovery_timer_reg;
reg [2:0] sleep_type_reg;
reg [3:0] pin_select_reg;
reg [15:0] snap_reg;
reg [15:0] snap_next;
reg [3:0] state_reg;
reg [3:0] state_next;
reg c3_hold_reg;
reg [2:0] sync1_reg;
reg [2:0] sync2_reg;
reg link_d_reg;
reg [31:0] rdata_next;
reg sel_ok;
reg [TW-1:0] c3_load;
reg pll_start;
reg [TW-1:0] pll_load;
wire pll_busy;
wire pll_done;

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        // Link pin idles high, no false rise after reset
        sync1_reg <= 3'h2;
        sync2_reg <= 3'h2;
        link_d_reg <= 1'b1;
    end else begin
        sync1_reg <= {mouse_irq_pin_i, link_halt_n_i, wake_i};
        sync2_reg <= sync1_reg;
        link_d_reg <= sync2_reg[1];
    end
end

wire wake_s = sync2_reg[0];
wire link_s = sync2_reg[1];
wire mouse_pin_s = sync2_reg[2];
wire link_rise = link_s & ~link_d_reg;

// ----------------------------------------
// APB access
// ----------------------------------------
wire apb_acc = psel_i & penable_i;
wire apb_done = apb_acc & pready_o;
wire apb_wr = apb_done & pwrite_i & ~pslverr_o;

wire cmd_wr = apb_wr & (paddr_i == `POSC_OFS_SLPCMD);
wire pos_cmd = cmd_wr & pwdata_i[`POSC_SLP_EN]
    & (pwdata_i[`POSC_SLEEP_TYPE_FIELD_LSB+2:`POSC_SLEEP_TYPE_FIELD_LSB] == `POSC_SLEEP_TYPE_FIELD_POS);
wire enter = pos_cmd & action_reg[`POSC_ACT_EN] & state_reg[0];

wire [3:0] pll_cnt1 = pll_recovery_timer_reg[3:0];
wire [3:0] pll_cnt2 = pll_recovery_timer_reg[7:4];
wire [31:0] pll_prod1 = ({{28{1'b0}}, pll_cnt1} + 32'h0000_0001) * PLL_UNIT_CYC;
wire [31:0] pll_prod2 = ({{28{1'b0}}, pll_cnt2} + 32'h0000_0001) * PLL_UNIT_CYC;

always @* begin
    sel_ok = 1'b1;
    rdata_next = 32'h0000_0000;
    case (paddr_i)
        `POSC_OFS_ACTION: rdata_next[15:0] = action_reg;
        `POSC_OFS_C3TIME: rdata_next[1:0] = c3_exit_timing_reg;
        `POSC_OFS_PLLTMR: rdata_next[7:0] = pll_recovery_timer_reg;
        `POSC_OFS_SLPCMD: rdata_next[`POSC_SLEEP_TYPE_FIELD_LSB+2:`POSC_SLEEP_TYPE_FIELD_LSB] = sleep_type_reg;
        `POSC_OFS_PINSEL: rdata_next[3:0] = pin_select_reg;
        `POSC_OFS_STATUS: rdata_next[4:0] = {pll_busy, c3_hold_reg, state_reg[3:1]};
        default: sel_ok = 1'b0;
    endcase
end

// One wait state, answer at second access cycle
always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
        prdata_o <= 32'h0000_0000;
    end else if (apb_acc & ~pready_o) begin
        pready_o <= 1'b1;
        pslverr_o <= ~sel_ok;
        prdata_o <= pwrite_i ? 32'h0000_0000 : rdata_next;
    end else begin
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
    end
end

// ----------------------------------------
// Register file
// ----------------------------------------
always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        action_reg <= `POSC_RST_ACTION;
        c3_exit_timing_reg <= `POSC_RST_C3TIME;
        pll_recovery_timer_reg <= `POSC_RST_PLLTMR;
        sleep_type_reg <= `POSC_RST_SLPTYP;
        pin_select_reg <= `POSC_RST_PINSEL;
    end else if (apb_wr) begin
        case (paddr_i)
            `POSC_OFS_ACTION: action_reg <= pwdata_i[15:0] & `POSC_ACT_WMASK;
            `POSC_OFS_C3TIME: c3_exit_timing_reg <= pwdata_i[1:0];
            `POSC_OFS_PLLTMR: pll_recovery_timer_reg <= pwdata_i[7:0];
            `POSC_OFS_SLPCMD: sleep_type_reg <= pwdata_i[`POSC_SLEEP_TYPE_FIELD_LSB+2:`POSC_SLEEP_TYPE_FIELD_LSB];
            `POSC_OFS_PINSEL: pin_select_reg <= pwdata_i[3:0];
            default: sleep_type_reg <= sleep_type_reg;
        endcase
    end
end

// ----------------------------------------
// Suspend sequencer
// ----------------------------------------
always @* begin
    state_next = state_reg;
    snap_next = snap_reg;
    pll_start = 1'b0;
    pll_load = {TW{1'b0}};
    case (state_reg)
        ST_IDLE: begin
            if (enter) begin
                state_next = ST_SUSPEND_PIN_ENABLE;
                snap_next = action_reg;
            end
        end
        ST_SUSPEND_PIN_ENABLE: begin
            if (wake_s) begin
                state_next = ST_REL1;
                pll_start = 1'b1;
                pll_load = pll_prod1[TW-1:0];
            end
        end
        ST_REL1: begin
            if (pll_done) begin
                state_next = ST_REL2;
                pll_start = 1'b1;
                pll_load = pll_prod2[TW-1:0];
            end
        end
        ST_REL2: begin
            if (pll_done) begin
                state_next = ST_IDLE;
                snap_next = 16'h0000;
            end
        end
        default: begin
            state_next = ST_IDLE;
            snap_next = 16'h0000;
        end
    endcase
end

always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        state_reg <= ST_IDLE;
        snap_reg <= 16'h0000;
    end else begin
        state_reg <= state_next;
        snap_reg <= snap_next;
    end
end

posc_timer #(
    .W(TW)
) u_pll_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(pll_start),
    .load_i(pll_load),
    .busy_o(pll_busy),
    .done_o(pll_done)
);

// ----------------------------------------
// C3 exit graphics stop release
// ----------------------------------------
wire c3_busy;
wire c3_done;
wire c3_start = link_rise & c3_hold_reg & ~c3_busy;

wire [31:0] c3_dly0 = `POSC_C3_DLY0_CYC;
wire [31:0] c3_dly1 = `POSC_C3_DLY1_CYC;
wire [31:0] c3_dly2 = `POSC_C3_DLY2_CYC;
wire [31:0] c3_dly3 = C3_DLY3_CYC;

always @* begin
    case (c3_exit_timing_reg)
        2'b00: c3_load = c3_dly0[TW-1:0];
        2'b01: c3_load = c3_dly1[TW-1:0];
        2'b10: c3_load = c3_dly2[TW-1:0];
        default: c3_load = c3_dly3[TW-1:0];
    endcase
end

posc_timer #(
    .W(TW)
) u_c3_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(c3_start),
    .load_i(c3_load),
    .busy_o(c3_busy),
    .done_o(c3_done)
);

// New C3 request wins over a finishing release
always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        c3_hold_reg <= 1'b0;
    end else if (c3_graphics_stop_i) begin
        c3_hold_reg <= 1'b1;
    end else if (c3_done) begin
        c3_hold_reg <= 1'b0;
    end
end

// ----------------------------------------
// Pin and interrupt outputs
// ----------------------------------------
wire st_suspend_pin_enable = state_reg[1];
wire st_early = state_reg[1] | state_reg[2];
wire st_any = ~state_reg[0];
wire en = snap_reg[`POSC_ACT_EN];
wire tmr_mask = (st_any & en & snap_reg[`POSC_ACT_TIMER]) | (enter & action_reg[`POSC_ACT_TIMER]);
wire ms_mask = (st_any & en & snap_reg[`POSC_ACT_MOUSE]) | (enter & action_reg[`POSC_ACT_MOUSE]);

always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        stop_grant_request_n_o <= 1'b1;
        suspend_n_o <= 1'b1;
        processor_sleep_n_o <= 1'b1;
        dc_stop_out_n_o <= 1'b1;
        graphics_stop_out_n_o <= 1'b1;
        pci_clock_halt_n_o <= 1'b1;
        processor_clock_halt_n_o <= 1'b1;
        timer_irq_o <= 1'b0;
        mouse_irq_o <= 1'b0;
    end else begin
        stop_grant_request_n_o <= ~(st_any & en);
        suspend_n_o <= ~(st_early & en & snap_reg[`POSC_ACT_SUSPEND_PIN_ENABLE]);
        processor_sleep_n_o <= ~(st_early & en & snap_reg[`POSC_ACT_SLEEP]
            & pin_select_reg[`POSC_SEL_SLEEP]);
        dc_stop_out_n_o <= ~(st_early & en & snap_reg[`POSC_ACT_DC_STOP_PIN_ENABLE]
            & pin_select_reg[`POSC_SEL_DC_STOP_PIN_ENABLE]);
        graphics_stop_out_n_o <= ~((st_early & en & snap_reg[`POSC_ACT_GFXSTP]) | c3_hold_reg)
            | ~pin_select_reg[`POSC_SEL_GFXSTP];
        pci_clock_halt_n_o <= ~(st_suspend_pin_enable & en & snap_reg[`POSC_ACT_PCISTP]);
        processor_clock_halt_n_o <= ~(st_suspend_pin_enable & en & snap_reg[`POSC_ACT_CPUSTP]
            & pin_select_reg[`POSC_SEL_CPUSTP]);
        timer_irq_o <= timer_irq_i & ~tmr_mask;
        mouse_irq_o <= (mouse_pin_s | mouse_irq_serial_i) & ~ms_mask;
    end
end

endmodule // posc_top

// >>> tb/posc_props.sv
`timescale 1ns/1ps
module posc_props (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // Register bus
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire pready_o,
    input wire pslverr_o,
    // Link and interrupts
    input wire link_halt_n_i,
    input wire c3_graphics_stop_i,
    input wire timer_irq_i,
    input wire mouse_irq_pin_i,
    input wire mouse_irq_serial_i,
    input wire timer_irq_o,
    input wire mouse_irq_o,
    // Power pins
    input wire stop_grant_request_n_o,
    input wire suspend_n_o,
    input wire processor_sleep_n_o,
    input wire dc_stop_out_n_o,
    input wire graphics_stop_out_n_o,
    input wire pci_clock_halt_n_o,
    input wire processor_clock_halt_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire cmd_w = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h0C && pwdata_i[13]
        && pwdata_i[12:10] == 3'h1;
    wire any_low = !(suspend_n_o && processor_sleep_n_o && dc_stop_out_n_o && pci_clock_halt_n_o
        && processor_clock_halt_n_o);
    sequence s_req; psel_i && penable_i && !pready_o; endsequence
    sequence s_c3_end; $rose(graphics_stop_out_n_o) ##0 stop_grant_request_n_o; endsequence
    property p_apb_wait; s_req |=> pready_o; endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("pready late");
    property p_apb_err; pslverr_o |-> pready_o && psel_i && penable_i; endproperty
    a_apb_err: assert property (p_apb_err) else $error("pslverr outside access");
    property p_cmd; $fell(stop_grant_request_n_o) |-> $past(cmd_w) || $past(cmd_w, 2); endproperty
    a_cmd: assert property (p_cmd) else $error("stop grant without command");
    property p_gate; any_low |-> !stop_grant_request_n_o; endproperty
    a_gate: assert property (p_gate) else $error("pin low without stop grant");
    property p_timer; timer_irq_o |-> $past(timer_irq_i); endproperty
    a_timer: assert property (p_timer) else $error("timer irq without source");
    property p_mouse;
        mouse_irq_o |-> $past(mouse_irq_serial_i) || $past(mouse_irq_pin_i, 2) || $past(mouse_irq_pin_i, 3)
            || $past(mouse_irq_pin_i, 4);
    endproperty
    a_mouse: assert property (p_mouse) else $error("mouse irq without source");
    property p_release;
        $rose(stop_grant_request_n_o) |-> !any_low;
    endproperty
    a_release: assert property (p_release) else $error("stop grant released first");
    property p_phase; $rose(suspend_n_o) |-> pci_clock_halt_n_o && processor_clock_halt_n_o; endproperty
    a_phase: assert property (p_phase) else $error("clock halts released late");
    property p_c3; s_c3_end |-> $past(link_halt_n_i, 20) && !$past(c3_graphics_stop_i); endproperty
    a_c3: assert property (p_c3) else $error("graphics released early");
endmodule // posc_props
bind posc_top posc_props u_props (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pready_o, .pslverr_o, .link_halt_n_i, .c3_graphics_stop_i, .timer_irq_i, .mouse_irq_pin_i,
    .mouse_irq_serial_i, .timer_irq_o, .mouse_irq_o, .stop_grant_request_n_o, .suspend_n_o,
    .processor_sleep_n_o, .dc_stop_out_n_o, .graphics_stop_out_n_o, .pci_clock_halt_n_o,
    .processor_clock_halt_n_o);

// >>> tb/posc_host_model.sv
`timescale 1ns/1ps
module posc_host_model (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // Processor side
    input wire stop_grant_request_n_i,
    input wire [7:0] wake_dly_i,
    output logic wake_o
);
    logic [7:0] cnt;
    // ----------------------------------------
    // Resume event after a programmable stay
    // ----------------------------------------
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i || stop_grant_request_n_i) begin
            cnt <= 8'h00;
            wake_o <= 1'b0;
        end else if (cnt == wake_dly_i) begin
            wake_o <= 1'b1;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // posc_host_model

// >>> tb/posc_top_bench.sv
`timescale 1ns/1ps
module posc_top_bench;
    localparam logic [31:0] CMD = 32'h0000_2400;
    logic clk_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, link_halt_n_i = 1;
    logic c3_graphics_stop_i = 0, timer_irq_i = 0, mouse_irq_pin_i = 0, mouse_irq_serial_i = 0;
    logic [7:0] paddr_i = 8'h00, wdly = 8'd30;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
    logic pready_o, pslverr_o, er, timer_irq_o, mouse_irq_o, wake_i;
    logic stop_grant_request_n_o, suspend_n_o, processor_sleep_n_o, dc_stop_out_n_o;
    logic graphics_stop_out_n_o, pci_clock_halt_n_o, processor_clock_halt_n_o;
    wire [6:0] pins = {stop_grant_request_n_o, suspend_n_o, processor_sleep_n_o, dc_stop_out_n_o,
        graphics_stop_out_n_o, pci_clock_halt_n_o, processor_clock_halt_n_o};
    int fail_count = 0, n_compared = 0, cyc = 0;

    posc_top #(.C3_DLY3_CYC(20), .PLL_UNIT_CYC(4)) DUT (.clk_i, .sys_rst_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .wake_i, .link_halt_n_i,
        .c3_graphics_stop_i, .timer_irq_i, .mouse_irq_pin_i, .mouse_irq_serial_i, .timer_irq_o,
        .mouse_irq_o, .stop_grant_request_n_o, .suspend_n_o, .processor_sleep_n_o, .dc_stop_out_n_o,
        .graphics_stop_out_n_o, .pci_clock_halt_n_o, .processor_clock_halt_n_o);
    posc_host_model HOST (.clk_i, .sys_rst_i, .stop_grant_request_n_i(stop_grant_request_n_o),
        .wake_dly_i(wdly), .wake_o(wake_i));

    // ----------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------
    initial forever #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            give_verdict;
        end
    end
    task give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_rng(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("Error at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1;
        penable_i <= 0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_regs;
        apb(0, 8'h00, 0);
        chk(rd, 32'h0000_8000);
        apb(0, 8'h04, 0);
        chk(rd, 32'h0000_0000);
        apb(0, 8'h08, 0);
        chk(rd, 32'h0000_000F);
        apb(1, 8'h00, 32'hFFFF_FFFF);
        apb(0, 8'h00, 0);
        chk(rd, 32'h0000_C17F);
        apb(1, 8'h00, 32'h0000_0002);
        apb(0, 8'h00, 0);
        chk(rd, 32'h0000_0002);
        apb(1, 8'h18, 32'h0000_FFFF);
        chk(er, 1'b1);
        apb(0, 8'h18, 0);
        chk(rd, 32'h0000_0000);
    endtask
    task t_off;
        apb(1, 8'h10, 32'h0000_000F);
        apb(1, 8'h00, 32'h0000_C17E);
        apb(1, 8'h0C, CMD);
        timer_irq_i <= 1;
        repeat (4) @(posedge clk_i);
        chk(pins, 7'h7F);
        chk(timer_irq_o, 1'b1);
        apb(1, 8'h00, 32'h0000_C17F);
        apb(1, 8'h0C, 32'h0000_2800);
        repeat (3) @(posedge clk_i);
        chk(pins, 7'h7F);
        // Type field reads back, enable bit reads 0
        apb(0, 8'h0C, 0);
        chk(rd, 32'h0000_0800);
    endtask
    task t_suspend_pin_enable;
        int t1, t2;
        apb(1, 8'h08, 32'h0000_0021);
        mouse_irq_serial_i <= 1;
        apb(1, 8'h0C, CMD);
        repeat (2) @(posedge clk_i);
        chk(pins, 7'h00);
        chk({timer_irq_o, mouse_irq_o}, 2'b00);
        mouse_irq_serial_i <= 0;
        mouse_irq_pin_i <= 1;
        repeat (5) @(posedge clk_i);
        chk(mouse_irq_o, 1'b0);
        // Status shows suspended before the wake arrives
        apb(0, 8'h14, 0);
        chk(rd, 32'h0000_0001);
        while (pci_clock_halt_n_o !== 1'b1) @(posedge clk_i);
        t1 = cyc;
        while (suspend_n_o !== 1'b1) @(posedge clk_i);
        t2 = cyc;
        chk_rng(t2 - t1, 8, 10);
        while (stop_grant_request_n_o !== 1'b1) @(posedge clk_i);
        chk_rng(cyc - t2, 12, 14);
        repeat (3) @(posedge clk_i);
        chk({timer_irq_o, mouse_irq_o}, 2'b11);
        mouse_irq_pin_i <= 0;
    endtask
    task t_sel;
        wdly <= 8'd5;
        apb(1, 8'h10, 0);
        apb(1, 8'h00, 32'h0000_0171);
        apb(1, 8'h0C, CMD);
        repeat (2) @(posedge clk_i);
        chk(pins, 7'h1F);
        chk(timer_irq_o, 1'b1);
        while (stop_grant_request_n_o !== 1'b1) @(posedge clk_i);
        timer_irq_i <= 0;
    endtask
    task t_c3;
        int d[4] = '{50, 1600, 3200, 20};
        int t;
        apb(1, 8'h10, 32'h0000_0004);
        for (int k = 0; k < 4; k++) begin
            apb(1, 8'h04, k);
            c3_graphics_stop_i <= 1;
            link_halt_n_i <= 0;
            repeat (4) @(posedge clk_i);
            chk(graphics_stop_out_n_o, 1'b0);
            c3_graphics_stop_i <= 0;
            @(posedge clk_i);
            link_halt_n_i <= 1;
            t = cyc;
            while (graphics_stop_out_n_o !== 1'b1) @(posedge clk_i);
            chk_rng(cyc - t, d[k], d[k] + 6);
        end
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 0;
        t_regs;
        t_off;
        t_suspend_pin_enable;
        t_sel;
        t_c3;
        give_verdict;
    end
endmodule // posc_top_bench
